// ### ptc_fm_sweep.sv
// triangular sweep generator for the fm current code
// assumes run_i comes from logic on the same clock
`timescale 1ns/100ps
module ptc_fm_sweep
  import ptc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              run_i,
  output logic [REG_W-1:0]       code_o
);

  // ==========================================================
  // step timer
  logic [7:0]       tick_ff;
  logic             step;
  logic [REG_W-1:0] code_ff;
  logic             up_ff;

  assign step = (tick_ff == 8'(FM_STEP_CYC - 1));

  // timer restarts whenever the sweep is stopped
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tick_ff <= 8'h00;
    else if (!run_i || step)
      tick_ff <= 8'h00;
    else
      tick_ff <= tick_ff + 8'h01;
  end

  // ==========================================================
  // up/down counter, turns at both ends so no code is skipped
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      code_ff <= 8'h00;
      up_ff   <= 1'b1;
    end
    else if (!run_i)
    begin
      code_ff <= 8'h00;
      up_ff   <= 1'b1;
    end
    else if (step)
    begin
      if (up_ff && code_ff == 8'hff)
      begin
        up_ff   <= 1'b0;
        code_ff <= 8'hfe;
      end
      else if (!up_ff && code_ff == 8'h00)
      begin
        up_ff   <= 1'b1;
        code_ff <= 8'h01;
      end
      else if (up_ff)
        code_ff <= code_ff + 8'h01;
      else
        code_ff <= code_ff - 8'h01;
    end
  end

  assign code_o = code_ff;

endmodule // ptc_fm_sweep

// ### ptc_pkg.sv
// constants for the pll test control register pair
// assumes a classic wishbone slave with 32-bit data and byte addressing
package ptc_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADR_W  = 10;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = 4;
  localparam int REG_W  = 8;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_TEST_A = 8'h3d;
  localparam logic [7:0] IDX_SHARED = 8'h3e;
  localparam logic [7:0] IDX_STATUS = 8'h40;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_TEST_A = 8'h00;
  localparam logic [7:0] RST_TEST_B = 8'h00;
  localparam logic [7:0] RST_FM_AMP = 8'h00;

  // ==========================================================
  // fields of pll_test_ctrl_a
  localparam int A_REG_SEL    = 7;
  localparam int A_GFE        = 6;
  localparam int A_XFC_ROUTE  = 5;
  localparam int A_FC_FORCE   = 4;
  localparam int A_VCO_MSB    = 3;
  localparam int A_RSVD       = 2;
  localparam int A_FM_X4      = 1;
  localparam int A_CRYSTAL_PIN_DIN   = 0;

  // ==========================================================
  // fields of pll_test_ctrl_b
  localparam int B_PFD_FORCE  = 7;
  localparam int B_TCLK_EN    = 6;
  localparam int B_TCLK_SEL_H = 5;
  localparam int B_TCLK_SEL_L = 4;
  localparam int B_MON_DIS    = 3;
  localparam int B_EXT_SQW    = 2;
  localparam int B_FORCE_UP   = 1;
  localparam int B_FORCE_DN   = 0;

  // ==========================================================
  // test clock choices and fm scaling
  localparam int TCLK_N = 4;
  localparam int REF_RANGE_BIT = 1;
  localparam logic [2:0] FM_MULT_X1 = 3'h1;
  localparam logic [2:0] FM_MULT_X4 = 3'h4;
  localparam logic [2:0] VCO_GAIN_MAX = 3'h7;

  // ==========================================================
  // timing of one triangular sweep step
  localparam int CLK_PERIOD_NS = 8;
  localparam int FM_STEP_NS    = 1000;
  localparam int FM_STEP_CYC   = (FM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // register decode result
  typedef enum logic [2:0] {REG_NONE, REG_A, REG_B, REG_FM, REG_STAT} ptc_reg_e;

endpackage

// ### ptc_regs.sv
// pll test control register pair with fm amplitude register, wishbone slave
// assumes a classic wishbone master on CLOCK_I and all control inputs on the same clock
//
// How it works
// - reg select 0 shows test register b at the shared index, 1 shows the fm amplitude register.
// - reg select 0 gives a triangular fm code while fm runs, 1 gives the stored amplitude.
// - the glitch filter bit goes out as enable (1) or disable (0) request to the test controller.
// - the filter route bit set connects the external filter pin to the filter node.
// - with node force set, reference range bit 1 picks one third (1) or one half (0) supply.
// - the vco gain msb joins the two low gain bits into a three-bit code, all ones is top range.
// - the fm gain bit multiplies the fm amplitude by four, otherwise by one.
// - the crystal input bit enables the crystal pin as a digital input for oscillator test.
// - test register b reads while reg select is clear and takes writes only then and in special mode.
// - test clock select 00 rc, 01 oscillator, 10 vco, 11 vco divided by four.
// - test register a has its own index, reads any time, writes in special mode, reset clears gfe.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/100ps
module ptc_regs
  import ptc_pkg::*;
(
  input  wire logic              CLOCK_I,
  input  wire logic              RST_I,
  // wishbone slave
  input  wire logic              CYC_I,
  input  wire logic              STB_I,
  input  wire logic              WE_I,
  input  wire logic [ADR_W-1:0]  ADR_I,
  input  wire logic [SEL_W-1:0]  SEL_I,
  input  wire logic [DAT_W-1:0]  DAT_I,
  output logic      [DAT_W-1:0]  DAT_O,
  output logic                   ACK_O,
  // device context
  input  wire logic              SPECIAL_MODE_I,
  input  wire logic              FM_RUN_ENABLE_I,
  input  wire logic [1:0]        REF_FREQ_RANGE_I,
  input  wire logic [1:0]        VCO_GAIN_LO_I,
  // controls toward the analog unit
  output logic [REG_W-1:0]       FM_CURRENT_CODE_O,
  output logic [2:0]             FM_GAIN_MULT_O,
  output logic [REG_W+1:0]       FM_SCALED_CODE_O,
  output logic                   GLITCH_FILTER_REQ_O,
  output logic                   EXT_FILTER_ROUTE_O,
  output logic                   FILTER_FORCE_THIRD_O,
  output logic                   FILTER_FORCE_HALF_O,
  output logic [2:0]             VCO_GAIN_CODE_O,
  output logic                   VCO_RANGE_MAX_O,
  output logic                   CRYSTAL_DIN_EN_O,
  output logic                   PFD_FORCE_EN_O,
  output logic                   PFD_FORCE_UP_O,
  output logic                   PFD_FORCE_DOWN_O,
  output logic                   TEST_CLK_EN_O,
  output logic [TCLK_N-1:0]      TEST_CLK_ONEHOT_O,
  output logic                   MONITOR_DISABLE_O,
  output logic                   EXT_SQW_EN_O
);

  // ==========================================================
  // address decode

  // shared index answers for register b or fm amplitude
  // misaligned addresses never hit, so a stray byte
  // write cannot land in a neighbouring register
  function automatic ptc_reg_e decode_reg(input logic [ADR_W-1:0] adr,
                                          input logic             fm_sel);
    logic [7:0] idx;
    idx = adr[ADR_W-1:2];
    if (adr[1:0] != 2'b00)
      decode_reg = REG_NONE;
    else if (idx == IDX_TEST_A)
      decode_reg = REG_A;
    else if (idx == IDX_SHARED && !fm_sel)
      decode_reg = REG_B;
    else if (idx == IDX_SHARED)
      decode_reg = REG_FM;
    else if (idx == IDX_STATUS)
      decode_reg = REG_STAT;
    else
      decode_reg = REG_NONE;
  endfunction

  // ==========================================================
  // storage
  // software registers and the bus answer
  logic [REG_W-1:0] test_a_ff;
  logic [REG_W-1:0] test_b_ff;
  logic [REG_W-1:0] fm_amp_ff;
  logic             ack_ff;
  logic [DAT_W-1:0] rdata_ff;

  // bus decode, combinational off the live request
  logic             req;
  logic             wr_take;
  logic             wr_ok;
  ptc_reg_e         hit;

  // read side
  logic [REG_W-1:0] rd_byte;
  logic [REG_W-1:0] status_byte;

  // fm path ahead of its flops
  logic [REG_W-1:0] sweep_code;
  logic [REG_W-1:0] nxt_fm_code;
  logic [REG_W-1:0] fm_code_ff;

  // test clock selects ahead of their flops
  logic [TCLK_N-1:0] nxt_clk_onehot;

  // ==========================================================
  // wishbone handshake
  assign req     = CYC_I && STB_I;
  assign hit     = decode_reg(ADR_I, test_a_ff[A_REG_SEL]);
  // writes land on the edge where the master sees ack
  // lane 0 carries the whole register, other lanes idle
  assign wr_take = req && WE_I && ack_ff && SEL_I[0];
  // outside special mode the write is acked but dropped
  // software sees no error and must read back to know
  assign wr_ok   = wr_take && SPECIAL_MODE_I;

  // ack one cycle after the request, dropped the cycle after
  // the fixed wait state gives decode a full cycle to settle
  // before the write edge
  // a master holding cyc and stb past ack is answered again,
  // so every access costs at least two cycles
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      ack_ff <= 1'b0;
    else
      ack_ff <= req && !ack_ff;
  end

  assign ACK_O = ack_ff;

  // ==========================================================
  // test register a, power-on reset clears every bit, gfe among them
  // the reserved bit is forced low so it always reads zero
  // one reset only: power-on and later resets look alike
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      test_a_ff <= RST_TEST_A;
    else if (wr_ok && hit == REG_A)
    begin
      test_a_ff <= DAT_I[REG_W-1:0];
      test_a_ff[A_RSVD] <= 1'b0;
    end
  end

  // ==========================================================
  // test register b, reachable only while reg select is clear
  // since the same index then belongs to the fm amplitude
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      test_b_ff <= RST_TEST_B;
    else if (wr_ok && hit == REG_B)
      test_b_ff <= DAT_I[REG_W-1:0];
  end

  // ==========================================================
  // fm amplitude register, same write gate as the test pair
  // it keeps its value while hidden, so flipping reg select
  // back restores the stored code without a rewrite
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      fm_amp_ff <= RST_FM_AMP;
    else if (wr_ok && hit == REG_FM)
      fm_amp_ff <= DAT_I[REG_W-1:0];
  end

  // ==========================================================
  // read path
  // status shows the code as the analog unit sees it,
  // one cycle behind the sweep or amplitude register that it selects
  assign status_byte = fm_code_ff;

  // read mux; unmapped and misaligned addresses read zero
  // the status index has no storage, writes to it vanish
  always_comb
  begin
    rd_byte = 8'h00;
    case (hit)
      REG_A:    rd_byte = test_a_ff;
      REG_B:    rd_byte = test_b_ff;
      REG_FM:   rd_byte = fm_amp_ff;
      REG_STAT: rd_byte = status_byte;
      default:  rd_byte = 8'h00;
    endcase
  end

  // data captured with the ack and held until the next read
  // writes leave it alone, so a stale value lingers;
  // take it only on a read ack
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
      rdata_ff <= 32'h0000_0000;
    else if (req && !ack_ff && !WE_I)
      rdata_ff <= {24'h00_0000, rd_byte};
  end

  assign DAT_O = rdata_ff;

  // ==========================================================
  // frequency modulation code
  // the sweep is held cleared while the stored amplitude
  // drives the code, so sweep mode always restarts at zero
  ptc_fm_sweep u_sweep
  (
    .clk_i  (CLOCK_I),
    .rst_i  (RST_I),
    .run_i  (FM_RUN_ENABLE_I && !test_a_ff[A_REG_SEL]),
    .code_o (sweep_code)
  );

  // register select picks sweep or stored amplitude
  // with fm stopped in sweep mode the code parks at zero
  always_comb
  begin
    if (test_a_ff[A_REG_SEL])
      nxt_fm_code = fm_amp_ff;
    else if (FM_RUN_ENABLE_I)
      nxt_fm_code = sweep_code;
    else
      nxt_fm_code = 8'h00;
  end

  // code and its scaled form leave from flip-flops
  // scaling is a shift by two; the two extra bits keep
  // the top of the range, so nothing clips
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      fm_code_ff       <= 8'h00;
      FM_SCALED_CODE_O <= 10'h000;
      FM_GAIN_MULT_O   <= FM_MULT_X1;
    end
    else
    begin
      fm_code_ff <= nxt_fm_code;
      if (test_a_ff[A_FM_X4])
      begin
        FM_SCALED_CODE_O <= {nxt_fm_code, 2'b00};
        FM_GAIN_MULT_O   <= FM_MULT_X4;
      end
      else
      begin
        FM_SCALED_CODE_O <= {2'b00, nxt_fm_code};
        FM_GAIN_MULT_O   <= FM_MULT_X1;
      end
    end
  end

  // the same flop feeds the status read, so both agree
  assign FM_CURRENT_CODE_O = fm_code_ff;

  // ==========================================================
  // filter node and vco gain controls
  // every output here is one flop past its register bit
  // exclusion in hardware would hide a software slip
  // from the tester, which these bits exist to expose
  // the block does not police a second node driver, software keeps
  // route and force exclusive; both can be set and both go out
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      GLITCH_FILTER_REQ_O  <= 1'b0;
      EXT_FILTER_ROUTE_O   <= 1'b0;
      FILTER_FORCE_THIRD_O <= 1'b0;
      FILTER_FORCE_HALF_O  <= 1'b0;
      VCO_GAIN_CODE_O      <= 3'h0;
      VCO_RANGE_MAX_O      <= 1'b0;
      CRYSTAL_DIN_EN_O     <= 1'b0;
    end
    else
    begin
      GLITCH_FILTER_REQ_O  <= test_a_ff[A_GFE];
      EXT_FILTER_ROUTE_O   <= test_a_ff[A_XFC_ROUTE];
      FILTER_FORCE_THIRD_O <= test_a_ff[A_FC_FORCE] &&
                              REF_FREQ_RANGE_I[REF_RANGE_BIT];
      FILTER_FORCE_HALF_O  <= test_a_ff[A_FC_FORCE] &&
                              !REF_FREQ_RANGE_I[REF_RANGE_BIT];
      // low gain bits come live from the synthesizer side
      VCO_GAIN_CODE_O      <= {test_a_ff[A_VCO_MSB], VCO_GAIN_LO_I};
      VCO_RANGE_MAX_O      <= ({test_a_ff[A_VCO_MSB], VCO_GAIN_LO_I}
                               == VCO_GAIN_MAX);
      CRYSTAL_DIN_EN_O     <= test_a_ff[A_CRYSTAL_PIN_DIN];
    end
  end

  // ==========================================================
  // test clock observation select, one line per clock source
  // index 0 rc, 1 oscillator, 2 vco, 3 vco divided by four
  // the clocks are switched in the analog unit, only
  // selects leave here, all low while the enable is clear
  genvar gi;
  generate
    for (gi = 0; gi < TCLK_N; gi++)
    begin : g_tclk
      assign nxt_clk_onehot[gi] = test_b_ff[B_TCLK_EN] &&
        (test_b_ff[B_TCLK_SEL_H:B_TCLK_SEL_L] == 2'(gi));
    end
  endgenerate

  // ==========================================================
  // phase detector and oscillator test controls
  // monitor disable and square wave go straight out;
  // the tester owns the oscillator while they are set
  always_ff @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      PFD_FORCE_EN_O    <= 1'b0;
      PFD_FORCE_UP_O    <= 1'b0;
      PFD_FORCE_DOWN_O  <= 1'b0;
      TEST_CLK_EN_O     <= 1'b0;
      TEST_CLK_ONEHOT_O <= 4'h0;
      MONITOR_DISABLE_O <= 1'b0;
      EXT_SQW_EN_O      <= 1'b0;
    end
    else
    begin
      PFD_FORCE_EN_O    <= test_b_ff[B_PFD_FORCE];
      // up and down only act while the loop is opened
      PFD_FORCE_UP_O    <= test_b_ff[B_PFD_FORCE] && test_b_ff[B_FORCE_UP];
      PFD_FORCE_DOWN_O  <= test_b_ff[B_PFD_FORCE] && test_b_ff[B_FORCE_DN];
      TEST_CLK_EN_O     <= test_b_ff[B_TCLK_EN];
      TEST_CLK_ONEHOT_O <= nxt_clk_onehot;
      MONITOR_DISABLE_O <= test_b_ff[B_MON_DIS];
      EXT_SQW_EN_O      <= test_b_ff[B_EXT_SQW];
    end
  end

endmodule // ptc_regs

// ### ptc_regs_assertions.sv
// port-level checker for the pll test control register pair
// assumes it is bound to ptc_regs and that every port runs on CLOCK_I
`timescale 1ns/100ps
module ptc_regs_chk
  import ptc_pkg::*;
(
  input wire logic              CLOCK_I,
  input wire logic              RST_I,
  input wire logic              CYC_I,
  input wire logic              STB_I,
  input wire logic              WE_I,
  input wire logic [ADR_W-1:0]  ADR_I,
  input wire logic [SEL_W-1:0]  SEL_I,
  input wire logic [DAT_W-1:0]  DAT_I,
  input wire logic              ACK_O,
  input wire logic              SPECIAL_MODE_I,
  input wire logic [1:0]        REF_FREQ_RANGE_I,
  input wire logic [1:0]        VCO_GAIN_LO_I,
  input wire logic [2:0]        FM_GAIN_MULT_O,
  input wire logic              GLITCH_FILTER_REQ_O,
  input wire logic              EXT_FILTER_ROUTE_O,
  input wire logic              FILTER_FORCE_THIRD_O,
  input wire logic              FILTER_FORCE_HALF_O,
  input wire logic [2:0]        VCO_GAIN_CODE_O,
  input wire logic              VCO_RANGE_MAX_O,
  input wire logic              CRYSTAL_DIN_EN_O,
  input wire logic              PFD_FORCE_EN_O,
  input wire logic              PFD_FORCE_UP_O,
  input wire logic              PFD_FORCE_DOWN_O,
  input wire logic              TEST_CLK_EN_O,
  input wire logic [TCLK_N-1:0] TEST_CLK_ONEHOT_O
);
  // ==========================================================
  // write decode; a write lands at the edge where ack is high
  logic wr_any;
  logic wr_a;
  assign wr_any = CYC_I && STB_I && WE_I && ACK_O && SEL_I[0];
  assign wr_a   = wr_any && SPECIAL_MODE_I && (ADR_I == {IDX_TEST_A, 2'h0});

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);

  // ==========================================================
  // bus answer, then register a fields and the write gate, two edges after the write
  a_ack_pulse: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O ##1 !ACK_O)
    else $error("ack is not a single pulse one cycle after the request");
  a_gfe_follow: assert property (wr_a |=> ##1 GLITCH_FILTER_REQ_O == $past(DAT_I[A_GFE], 2))
    else $error("glitch filter request does not follow the written bit");
  a_route_follow: assert property (wr_a |=> ##1 EXT_FILTER_ROUTE_O == $past(DAT_I[A_XFC_ROUTE], 2))
    else $error("filter pin route does not follow the written bit");
  a_crystal_pin_follow: assert property (wr_a |=> ##1 CRYSTAL_DIN_EN_O == $past(DAT_I[A_CRYSTAL_PIN_DIN], 2))
    else $error("crystal input enable does not follow the written bit");
  a_fm_gain: assert property (wr_a |=> ##1
    FM_GAIN_MULT_O == ($past(DAT_I[A_FM_X4], 2) ? FM_MULT_X4 : FM_MULT_X1))
    else $error("fm gain multiplier wrong after write");
  // blocked writes must leave the gfe, route, crystal, pfd force and test clock enable outputs alone
  a_write_gate: assert property (wr_any && !SPECIAL_MODE_I |=> ##1 $stable({GLITCH_FILTER_REQ_O,
    EXT_FILTER_ROUTE_O, CRYSTAL_DIN_EN_O, PFD_FORCE_EN_O, TEST_CLK_EN_O}))
    else $error("write outside special mode changed an output");

  // ==========================================================
  // relations between live inputs and derived outputs, and among the pfd and test clock outputs
  a_force_level: assert property (FILTER_FORCE_THIRD_O || FILTER_FORCE_HALF_O |->
    FILTER_FORCE_THIRD_O != FILTER_FORCE_HALF_O &&
    FILTER_FORCE_THIRD_O == $past(REF_FREQ_RANGE_I[REF_RANGE_BIT]))
    else $error("forced filter level does not match reference range bit");
  a_vco_code: assert property (!$past(RST_I) |-> VCO_GAIN_CODE_O[1:0] == $past(VCO_GAIN_LO_I)
    && VCO_RANGE_MAX_O == (VCO_GAIN_CODE_O == VCO_GAIN_MAX))
    else $error("vco gain code or top range flag wrong");
  a_pfd_gate: assert property (PFD_FORCE_UP_O || PFD_FORCE_DOWN_O |-> PFD_FORCE_EN_O)
    else $error("charge pump forced without phase detector force");
  a_tclk_sel: assert property ($onehot0(TEST_CLK_ONEHOT_O) &&
    TEST_CLK_EN_O == |TEST_CLK_ONEHOT_O)
    else $error("test clock select not one-hot under its enable");
endmodule // ptc_regs_chk

// ### tb_ptc_regs.sv
// self-checking bench for the pll test control register pair
// assumes ptc_regs as the device, reached by a classic wishbone master
`timescale 1ns/100ps
module tb_ptc_regs
  import ptc_pkg::*;
;
  logic              CLOCK_I, RST_I, CYC_I, STB_I, WE_I, ACK_O;
  logic              SPECIAL_MODE_I, FM_RUN_ENABLE_I, GLITCH_FILTER_REQ_O, EXT_FILTER_ROUTE_O;
  logic              FILTER_FORCE_THIRD_O, FILTER_FORCE_HALF_O, VCO_RANGE_MAX_O;
  logic              CRYSTAL_DIN_EN_O, PFD_FORCE_EN_O, PFD_FORCE_UP_O, PFD_FORCE_DOWN_O;
  logic              TEST_CLK_EN_O, MONITOR_DISABLE_O, EXT_SQW_EN_O;
  logic [1:0]        REF_FREQ_RANGE_I, VCO_GAIN_LO_I;
  logic [2:0]        FM_GAIN_MULT_O, VCO_GAIN_CODE_O;
  logic [3:0]        SEL_I, TEST_CLK_ONEHOT_O;
  logic [7:0]        FM_CURRENT_CODE_O;
  logic [9:0]        ADR_I, FM_SCALED_CODE_O;
  logic [31:0]       DAT_I, DAT_O;
  int                errors;
  int                n_tests;
  localparam logic [9:0] AD_A = {IDX_TEST_A, 2'h0};
  localparam logic [9:0] AD_S = {IDX_SHARED, 2'h0};
  // rows: register a value, ref bit1, vco low bits, expected output vector
  localparam logic [22:0] ROWS [8] = '{
    {8'h40, 1'h0, 2'h0, 12'h801}, {8'h20, 1'h0, 2'h0, 12'h401},
    {8'h10, 1'h1, 2'h0, 12'h201}, {8'h10, 1'h0, 2'h0, 12'h101},
    {8'h0c, 1'h0, 2'h3, 12'h0f1}, {8'h08, 1'h0, 2'h1, 12'h0a1},
    {8'h02, 1'h0, 2'h0, 12'h004}, {8'h01, 1'h0, 2'h0, 12'h009}};

  ptc_regs ptc_regs_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I), .STB_I(STB_I),
    .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SPECIAL_MODE_I(SPECIAL_MODE_I), .FM_RUN_ENABLE_I(FM_RUN_ENABLE_I),
    .REF_FREQ_RANGE_I(REF_FREQ_RANGE_I), .VCO_GAIN_LO_I(VCO_GAIN_LO_I),
    .FM_CURRENT_CODE_O(FM_CURRENT_CODE_O), .FM_GAIN_MULT_O(FM_GAIN_MULT_O),
    .FM_SCALED_CODE_O(FM_SCALED_CODE_O), .GLITCH_FILTER_REQ_O(GLITCH_FILTER_REQ_O),
    .EXT_FILTER_ROUTE_O(EXT_FILTER_ROUTE_O), .FILTER_FORCE_THIRD_O(FILTER_FORCE_THIRD_O),
    .FILTER_FORCE_HALF_O(FILTER_FORCE_HALF_O), .VCO_GAIN_CODE_O(VCO_GAIN_CODE_O),
    .VCO_RANGE_MAX_O(VCO_RANGE_MAX_O), .CRYSTAL_DIN_EN_O(CRYSTAL_DIN_EN_O),
    .PFD_FORCE_EN_O(PFD_FORCE_EN_O), .PFD_FORCE_UP_O(PFD_FORCE_UP_O),
    .PFD_FORCE_DOWN_O(PFD_FORCE_DOWN_O), .TEST_CLK_EN_O(TEST_CLK_EN_O),
    .TEST_CLK_ONEHOT_O(TEST_CLK_ONEHOT_O), .MONITOR_DISABLE_O(MONITOR_DISABLE_O),
    .EXT_SQW_EN_O(EXT_SQW_EN_O));

  // ==========================================================
  // clock, 8 ns period
  always #4 CLOCK_I = ~CLOCK_I;

  // ==========================================================
  // verdict, compare and bus tasks
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  // one classic cycle; request held until ack is sampled, bounded wait
  task automatic xfer(input logic we, input logic [9:0] adr, input logic [7:0] d,
                      input logic [3:0] sel, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CLOCK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= adr;
    SEL_I <= sel;
    DAT_I <= {24'h000000, d};
    do
    begin
      @(posedge CLOCK_I);
      n++;
    end
    while (ACK_O !== 1'b1 && n < 50);
    if (ACK_O !== 1'b1)
    begin
      $display("ERROR ack expected 1 seen %b", ACK_O);
      errors++;
      print_verdict();
    end
    q = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] adr, input logic [7:0] d);
    logic [31:0] q;
    xfer(1'b1, adr, d, 4'hf, q);
  endtask

  task automatic rd(input logic [9:0] adr, input logic [7:0] exp, input string name);
    logic [31:0] q;
    xfer(1'b0, adr, 8'h00, 4'hf, q);
    chk(name, {24'h000000, exp}, q);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [7:0]  v;
    logic [31:0] q;
    {CLOCK_I, CYC_I, STB_I, WE_I, FM_RUN_ENABLE_I} = 5'h00;
    {RST_I, SPECIAL_MODE_I} = 2'h3;
    {REF_FREQ_RANGE_I, VCO_GAIN_LO_I, SEL_I, ADR_I, DAT_I} = '0;
    errors = 0;
    n_tests = 0;
    repeat (4) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    rd(AD_A, 8'h00, "test_a reset");
    rd(AD_S, 8'h00, "test_b reset");
    chk("fm mult reset", 32'h1, FM_GAIN_MULT_O);
    $display("test reset done");
    // open the loop first, as routing or forcing the node asks
    wr(AD_S, 8'h80);
    // each row writes register a and checks every field it drives
    for (int i = 0; i < 8; i++)
    begin
      REF_FREQ_RANGE_I <= {ROWS[i][14], 1'b0};
      VCO_GAIN_LO_I <= ROWS[i][13:12];
      wr(AD_A, ROWS[i][22:15]);
      rd(AD_A, ROWS[i][22:15] & 8'hfb, "test_a readback");
      chk("test_a outputs", ROWS[i][11:0], {GLITCH_FILTER_REQ_O, EXT_FILTER_ROUTE_O,
        FILTER_FORCE_THIRD_O, FILTER_FORCE_HALF_O, VCO_GAIN_CODE_O, VCO_RANGE_MAX_O,
        CRYSTAL_DIN_EN_O, FM_GAIN_MULT_O});
    end
    $display("test table done");
    // writes outside special mode, without byte lane, or off the map are dropped
    SPECIAL_MODE_I <= 1'b0;
    wr(AD_A, 8'h7b);
    wr(AD_S, 8'hff);
    SPECIAL_MODE_I <= 1'b1;
    xfer(1'b1, AD_A, 8'h40, 4'he, q);
    wr(10'h3fc, 8'h40);
    wr(AD_A + 10'h1, 8'h40);
    rd(AD_A, 8'h01, "test_a locked");
    rd(AD_S, 8'h80, "test_b locked");
    $display("test locked done");
    // every test clock choice, monitor, square wave and force up/down toggled along, pfd force and test clock enable held set
    for (int s = 0; s < 4; s++)
    begin
      v = {2'h3, s[1:0], s[1:0], s[1:0]};
      wr(AD_S, v);
      rd(AD_S, v, "test_b readback");
      chk("test_b outputs", {2'h3, 4'h1 << s, s[1], s[0], s[1], s[0]}, {PFD_FORCE_EN_O,
        TEST_CLK_EN_O, TEST_CLK_ONEHOT_O, MONITOR_DISABLE_O, EXT_SQW_EN_O,
        PFD_FORCE_UP_O, PFD_FORCE_DOWN_O});
    end
    $display("test clock select done");
    // amplitude register takes the shared index and drives the fm code
    wr(AD_A, 8'h82);
    wr(AD_S, 8'h5a);
    rd(AD_S, 8'h5a, "fm amplitude readback");
    rd({IDX_STATUS, 2'h0}, 8'h5a, "fm code status");
    chk("fm code stored", 32'h5a, FM_CURRENT_CODE_O);
    chk("fm scaled x4", 32'h168, FM_SCALED_CODE_O);
    wr(AD_A, 8'h00);
    rd(AD_S, 8'hff, "test_b visible again");
    chk("fm code idle", 32'h0, FM_CURRENT_CODE_O);
    // sweep climbs one step per FM_STEP_CYC; sampled mid-step to avoid edges
    FM_RUN_ENABLE_I <= 1'b1;
    repeat (FM_STEP_CYC * 4 + FM_STEP_CYC / 2) @(posedge CLOCK_I);
    chk("fm sweep step", 32'h4, FM_CURRENT_CODE_O);
    chk("fm scaled x1", 32'h4, FM_SCALED_CODE_O);
    wr(AD_A, 8'hc0);
    repeat (4) @(posedge CLOCK_I);
    chk("fm code stored in run", 32'h5a, FM_CURRENT_CODE_O);
    $display("test fm done");
    // reset in mid-run clears the glitch filter request with the rest
    RST_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    rd(AD_A, 8'h00, "test_a after reset");
    chk("glitch request after reset", 32'h0, GLITCH_FILTER_REQ_O);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_ptc_regs

bind ptc_regs ptc_regs_chk ptc_regs_chk_i (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CYC_I(CYC_I),
  .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .ACK_O(ACK_O),
  .SPECIAL_MODE_I(SPECIAL_MODE_I), .REF_FREQ_RANGE_I(REF_FREQ_RANGE_I),
  .VCO_GAIN_LO_I(VCO_GAIN_LO_I), .FM_GAIN_MULT_O(FM_GAIN_MULT_O),
  .GLITCH_FILTER_REQ_O(GLITCH_FILTER_REQ_O), .EXT_FILTER_ROUTE_O(EXT_FILTER_ROUTE_O),
  .FILTER_FORCE_THIRD_O(FILTER_FORCE_THIRD_O), .FILTER_FORCE_HALF_O(FILTER_FORCE_HALF_O),
  .VCO_GAIN_CODE_O(VCO_GAIN_CODE_O), .VCO_RANGE_MAX_O(VCO_RANGE_MAX_O),
  .CRYSTAL_DIN_EN_O(CRYSTAL_DIN_EN_O), .PFD_FORCE_EN_O(PFD_FORCE_EN_O),
  .PFD_FORCE_UP_O(PFD_FORCE_UP_O), .PFD_FORCE_DOWN_O(PFD_FORCE_DOWN_O),
  .TEST_CLK_EN_O(TEST_CLK_EN_O), .TEST_CLK_ONEHOT_O(TEST_CLK_ONEHOT_O));
